// >>> src/lpup_fifo.sv
// Word FIFO feeding the serializer
`timescale 1ns/1ps
`default_nettype none
module lpup_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign o_in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_ptr != rd_ptr;
  assign o_out_data = mem[rd_ptr[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // lpup_fifo
`default_nettype wire

// >>> src/lpup_palette_ram.sv
// Palette lookup table storage with host and pixel read ports
`timescale 1ns/1ps
`default_nettype none
module lpup_palette_ram #(
  parameter int ENTRIES = 256,
  parameter int DW = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic [$clog2(ENTRIES)-1:0] i_wr_addr,
  input wire logic [DW-1:0] i_wr_data,
  input wire logic [$clog2(ENTRIES)-1:0] i_host_addr,
  output logic [DW-1:0] o_host_data,
  input wire logic [$clog2(ENTRIES)-1:0] i_pix_addr,
  output logic [DW-1:0] o_pix_data
);
  initial begin
    if (ENTRIES != 256) $error("ENTRIES must be 256");
  end
  logic [DW-1:0] table_q [ENTRIES];
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < ENTRIES; k++) begin
        table_q[k] <= lpup_pkg::PAL_RESET;
      end
    end else if (i_wr_en) begin
      table_q[i_wr_addr] <= i_wr_data;
    end
  end
  assign o_host_data = table_q[i_host_addr];
  assign o_pix_data = table_q[i_pix_addr];
endmodule // lpup_palette_ram
`default_nettype wire

// >>> src/lpup_pkg.sv
// Package of constants for the pixel unpack and palette block
package lpup_pkg;
  localparam int WORD_W = 32;
  localparam int PAL_ENTRIES = 256;
  localparam int PAL_IDX_W = 8;
  localparam int PAL_W = 16;
  // Pixel width selector codes
  localparam logic [2:0] BPP_1 = 3'h0;
  localparam logic [2:0] BPP_2 = 3'h1;
  localparam logic [2:0] BPP_4 = 3'h2;
  localparam logic [2:0] BPP_8 = 3'h3;
  localparam logic [2:0] BPP_16 = 3'h4;
  localparam logic [2:0] BPP_24 = 3'h5;
  // Word ordering selector codes
  localparam logic [1:0] ORD_LITTLE = 2'h0;
  localparam logic [1:0] ORD_BIG = 2'h1;
  localparam logic [1:0] ORD_BYTE_REV = 2'h2;
  // Panel kind selector codes
  localparam logic [1:0] PANEL_TFT = 2'h0;
  localparam logic [1:0] PANEL_STN_MONO = 2'h1;
  localparam logic [1:0] PANEL_STN_COLOUR = 2'h2;
  // Index of the last pixel in a word per width
  localparam logic [4:0] LAST_PIX_1 = 5'h1F;
  localparam logic [4:0] LAST_PIX_2 = 5'h0F;
  localparam logic [4:0] LAST_PIX_4 = 5'h07;
  localparam logic [4:0] LAST_PIX_8 = 5'h03;
  localparam logic [4:0] LAST_PIX_16 = 5'h01;
  localparam logic [4:0] LAST_PIX_24 = 5'h00;
  // Palette entry fields
  localparam int RED_HI = 15;
  localparam int RED_LO = 11;
  localparam int GRN_HI = 10;
  localparam int GRN_LO = 5;
  localparam int BLU_HI = 4;
  localparam int BLU_LO = 0;
  localparam logic [15:0] PAL_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 8;
endpackage

// >>> src/lpup_top.sv
// Serializer and palette stage of the panel datapath
`timescale 1ns/1ps
`default_nettype none
// Function
// - Fetch words, emit 1..24 bit pixels
// - Little or big endian pixel ordering
// - 24 bpp packed and unpacked formats
// - Little endian: pixel zero in LSBs
// - Big endian: pixel zero in MSBs
// - Byte order kept, pixel order reversed per byte
// - Small pixels index the lookup table
// - Palette use by panel kind, width
// - Host reads and writes every entry
// - Entry in low half, word writes
// - 256 entries of 16 free bits
// - Entry holds red, green, blue fields
// - STN mono uses red top four
// - STN colour uses top four each
// - TFT passes all colour bits
// - TFT palette zeros unused data bits
// - Panel kind selects operating mode
// - New pixel only on data request
module lpup_top #(
  parameter int FIFO_DEPTH = lpup_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [2:0] i_bits_per_pixel_sel,
  input wire logic [1:0] i_word_ordering_sel,
  input wire logic [1:0] i_panel_kind_sel,
  input wire logic i_packed_24,
  input wire logic i_word_valid,
  output logic o_word_ready,
  input wire logic [31:0] i_word_data,
  input wire logic i_data_request,
  output logic o_pixel_valid,
  output logic [23:0] o_panel_data_bus,
  output logic o_palettized,
  input wire logic i_lut_write,
  input wire logic [7:0] i_lut_addr,
  input wire logic [31:0] i_lut_wdata,
  output logic [31:0] o_lut_rdata
);
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
    if (lpup_pkg::PAL_ENTRIES != (1 << lpup_pkg::PAL_IDX_W)) $error("table size and index differ");
    if (lpup_pkg::WORD_W != 32) $error("serializer handles 32-bit words only");
  end
  localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;
  logic [FILL_W-1:0] fill_count;
  logic [FILL_W-1:0] next_fill_count;
  logic word_push;
  logic fifo_valid;
  logic fifo_pop;
  logic [31:0] fifo_data;
  logic [15:0] lut_host_data;
  logic [15:0] lut_pix_data;
  logic [7:0] lut_index;
  // Serializer state
  logic [31:0] cur_word;
  logic [31:0] prev_word;
  logic cur_full;
  logic [4:0] pix_idx;
  logic [1:0] pack_phase;
  logic [4:0] next_pix_idx;
  logic [4:0] pix_per_word;
  logic [23:0] pixel;
  logic take_pixel;
  logic need_word;
  logic use_palette;

  lpup_fifo #(.WIDTH(lpup_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_in_valid(word_push),
    .o_in_ready(),
    .i_in_data(i_word_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );
  assign word_push = i_word_valid && o_word_ready;

  // Fill level kept here so the ready output comes from a flop
  always_comb begin
    next_fill_count = fill_count;
    if (word_push && !fifo_pop) begin
      next_fill_count = fill_count + 1'b1;
    end else if (!word_push && fifo_pop) begin
      next_fill_count = fill_count - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fill_count <= '0;
      o_word_ready <= 1'b0;
    end else begin
      fill_count <= next_fill_count;
      o_word_ready <= next_fill_count != FILL_W'(FIFO_DEPTH);
    end
  end

  lpup_palette_ram #(.ENTRIES(lpup_pkg::PAL_ENTRIES), .DW(lpup_pkg::PAL_W)) u_lut (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_wr_en(i_lut_write),
    .i_wr_addr(i_lut_addr),
    .i_wr_data(i_lut_wdata[15:0]),
    .i_host_addr(i_lut_addr),
    .o_host_data(lut_host_data),
    .i_pix_addr(lut_index),
    .o_pix_data(lut_pix_data)
  );

  // Host read returns the entry in the low half word
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lut_rdata <= 32'h00000000;
    end else begin
      o_lut_rdata <= {16'h0000, lut_host_data};
    end
  end

  // Index of the last pixel in a word for the selected width
  always_comb begin
    case (i_bits_per_pixel_sel)
      lpup_pkg::BPP_1: pix_per_word = lpup_pkg::LAST_PIX_1;
      lpup_pkg::BPP_2: pix_per_word = lpup_pkg::LAST_PIX_2;
      lpup_pkg::BPP_4: pix_per_word = lpup_pkg::LAST_PIX_4;
      lpup_pkg::BPP_8: pix_per_word = lpup_pkg::LAST_PIX_8;
      lpup_pkg::BPP_16: pix_per_word = lpup_pkg::LAST_PIX_16;
      default: pix_per_word = lpup_pkg::LAST_PIX_24;
    endcase
  end

  // Bit position selection by ordering
  function automatic logic [4:0] pos(input logic [4:0] idx, input logic [4:0] last,
                                     input logic [1:0] ord, input logic [2:0] sh);
    logic [4:0] r;
    r = idx;
    if (ord == lpup_pkg::ORD_BIG) begin
      r = last - idx;
    end else if (ord == lpup_pkg::ORD_BYTE_REV && sh < 3'h3) begin
      r = (idx & ~(5'h07 >> sh)) | ((5'h07 >> sh) - (idx & (5'h07 >> sh)));
    end
    return r;
  endfunction

  // Pixel extraction; pixel zero in the LSBs for little endian
  always_comb begin
    logic [4:0] p;
    logic [31:0] sh_word;
    p = pos(pix_idx, pix_per_word, i_word_ordering_sel, i_bits_per_pixel_sel);
    pixel = 24'h000000;
    sh_word = 32'h00000000;
    case (i_bits_per_pixel_sel)
      lpup_pkg::BPP_1: sh_word = cur_word >> p;
      lpup_pkg::BPP_2: sh_word = cur_word >> {p[3:0], 1'b0};
      lpup_pkg::BPP_4: sh_word = cur_word >> {p[2:0], 2'h0};
      lpup_pkg::BPP_8: sh_word = cur_word >> {p[1:0], 3'h0};
      lpup_pkg::BPP_16: sh_word = cur_word >> {p[0], 4'h0};
      default: sh_word = cur_word;
    endcase
    case (i_bits_per_pixel_sel)
      lpup_pkg::BPP_1: pixel = {23'h0, sh_word[0]};
      lpup_pkg::BPP_2: pixel = {22'h0, sh_word[1:0]};
      lpup_pkg::BPP_4: pixel = {20'h00000, sh_word[3:0]};
      lpup_pkg::BPP_8: pixel = {16'h0000, sh_word[7:0]};
      lpup_pkg::BPP_16: pixel = {8'h00, sh_word[15:0]};
      default: begin
        if (!i_packed_24) begin
          pixel = cur_word[23:0];
        end else begin
          case (pack_phase)
            2'h0: pixel = cur_word[23:0];
            2'h1: pixel = {cur_word[15:0], prev_word[31:24]};
            2'h2: pixel = {cur_word[7:0], prev_word[31:16]};
            default: pixel = cur_word[31:8];
          endcase
        end
      end
    endcase
  end

  assign lut_index = pixel[7:0];

  // Palette enable by panel kind and width
  always_comb begin
    case (i_panel_kind_sel)
      lpup_pkg::PANEL_TFT: use_palette = i_bits_per_pixel_sel <= lpup_pkg::BPP_8;
      lpup_pkg::PANEL_STN_MONO: use_palette = i_bits_per_pixel_sel <= lpup_pkg::BPP_2;
      lpup_pkg::PANEL_STN_COLOUR: use_palette = i_bits_per_pixel_sel <= lpup_pkg::BPP_8;
      default: use_palette = 1'b0;
    endcase
  end

  // Packed 24 bpp: no fetch after phase two, the last pixel is in the current word
  assign need_word = !cur_full;
  assign take_pixel = i_data_request && cur_full;
  assign fifo_pop = fifo_valid && (need_word ||
                    (take_pixel && pix_idx == pix_per_word && !(i_packed_24 &&
                     i_bits_per_pixel_sel == lpup_pkg::BPP_24 && pack_phase == 2'h2)));

  always_comb begin
    next_pix_idx = pix_idx + 5'h01;
    if (pix_idx == pix_per_word) begin
      next_pix_idx = 5'h00;
    end
  end

  // Word and index tracking
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_word <= 32'h00000000;
      prev_word <= 32'h00000000;
      cur_full <= 1'b0;
      pix_idx <= 5'h00;
      pack_phase <= 2'h0;
    end else if (take_pixel) begin
      pix_idx <= next_pix_idx;
      if (i_packed_24 && i_bits_per_pixel_sel == lpup_pkg::BPP_24) begin
        pack_phase <= pack_phase + 2'h1;
        if (pack_phase != 2'h2) begin
          prev_word <= cur_word;
          cur_full <= fifo_valid;
          cur_word <= fifo_data;
        end
      end else if (pix_idx == pix_per_word) begin
        cur_full <= fifo_valid;
        cur_word <= fifo_data;
      end
    end else if (need_word && fifo_valid) begin
      cur_word <= fifo_data;
      cur_full <= 1'b1;
    end
  end

  // Output formatting per panel kind
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pixel_valid <= 1'b0;
      o_panel_data_bus <= 24'h000000;
      o_palettized <= 1'b0;
    end else begin
      o_pixel_valid <= take_pixel;
      o_palettized <= use_palette;
      if (take_pixel) begin
        if (!use_palette) begin
          o_panel_data_bus <= pixel;
        end else if (i_panel_kind_sel == lpup_pkg::PANEL_STN_MONO) begin
          o_panel_data_bus <= {20'h00000, lut_pix_data[lpup_pkg::RED_HI -: 4]};
        end else if (i_panel_kind_sel == lpup_pkg::PANEL_STN_COLOUR) begin
          o_panel_data_bus <= {12'h000, lut_pix_data[lpup_pkg::RED_HI -: 4],
                               lut_pix_data[lpup_pkg::GRN_HI -: 4],
                               lut_pix_data[lpup_pkg::BLU_HI -: 4]};
        end else begin
          o_panel_data_bus <= {lut_pix_data[lpup_pkg::RED_HI:lpup_pkg::RED_LO], 3'h0,
                               lut_pix_data[lpup_pkg::GRN_HI:lpup_pkg::GRN_LO], 2'h0,
                               lut_pix_data[lpup_pkg::BLU_HI:lpup_pkg::BLU_LO], 3'h0};
        end
      end
    end
  end
endmodule // lpup_top
`default_nettype wire

// >>> verification/lpup_top_sva.sv
// Assertions for the pixel unpack and palette block
`timescale 1ns/1ps
`default_nettype none
module lpup_checker (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [2:0] i_bits_per_pixel_sel,
  input wire logic [1:0] i_panel_kind_sel,
  input wire logic i_data_request,
  input wire logic o_pixel_valid,
  input wire logic [23:0] o_panel_data_bus,
  input wire logic o_palettized,
  input wire logic i_lut_write,
  input wire logic [7:0] i_lut_addr,
  input wire logic [31:0] i_lut_wdata,
  input wire logic [31:0] o_lut_rdata
);
  logic tft, mono, colr, pal_exp;
  assign tft = i_panel_kind_sel == lpup_pkg::PANEL_TFT;
  assign mono = i_panel_kind_sel == lpup_pkg::PANEL_STN_MONO;
  assign colr = i_panel_kind_sel == lpup_pkg::PANEL_STN_COLOUR;
  assign pal_exp = ((tft || colr) && i_bits_per_pixel_sel <= lpup_pkg::BPP_8)
    || (mono && i_bits_per_pixel_sel <= lpup_pkg::BPP_2);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_valid_needs_req: assert property (
    o_pixel_valid |-> $past(i_data_request)) else $error("pixel without request");
  a_data_holds: assert property (
    !o_pixel_valid |-> $stable(o_panel_data_bus)) else $error("data moved without pixel");
  a_tft_zero_bits: assert property (
    o_pixel_valid && o_palettized && tft |-> (o_panel_data_bus & 24'h070307) == 24'h000000)
    else $error("unused panel bits not zero");
  a_mono_gray_width: assert property (
    o_pixel_valid && o_palettized && mono |-> o_panel_data_bus[23:4] == 20'h00000)
    else $error("mono shade too wide");
  a_colour_width: assert property (
    o_pixel_valid && o_palettized && colr |-> o_panel_data_bus[23:12] == 12'h000)
    else $error("colour too wide");
  a_bypass_width: assert property (
    o_pixel_valid && !o_palettized && i_bits_per_pixel_sel == lpup_pkg::BPP_16
    |-> o_panel_data_bus[23:16] == 8'h00) else $error("bypass pixel altered");
  a_pal_select: assert property (
    $stable({i_panel_kind_sel, i_bits_per_pixel_sel}) |=> o_palettized == $past(pal_exp))
    else $error("palette use wrong");
  a_lut_upper_zero: assert property (
    o_lut_rdata[31:16] == 16'h0000) else $error("table upper half not zero");
  a_lut_write_read: assert property (
    i_lut_write ##1 ($stable(i_lut_addr) && !i_lut_write)
    |=> o_lut_rdata[15:0] == $past(i_lut_wdata[15:0], 2)) else $error("table readback wrong");
  c_pal_pixel: cover property (o_pixel_valid && o_palettized);
  c_raw_pixel: cover property (o_pixel_valid && !o_palettized);
  c_lut_write: cover property (i_lut_write);
endmodule // lpup_checker
bind lpup_top lpup_checker u_lpup_checker (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
  .i_bits_per_pixel_sel(i_bits_per_pixel_sel), .i_panel_kind_sel(i_panel_kind_sel),
  .i_data_request(i_data_request), .o_pixel_valid(o_pixel_valid),
  .o_panel_data_bus(o_panel_data_bus), .o_palettized(o_palettized),
  .i_lut_write(i_lut_write), .i_lut_addr(i_lut_addr), .i_lut_wdata(i_lut_wdata),
  .o_lut_rdata(o_lut_rdata));
`default_nettype wire

// >>> verification/lpup_top_tb.sv
// Self-checking testbench for the pixel unpack and palette block
`timescale 1ns/1ps
`default_nettype none
module lpup_top_tb;
  logic i_clk_sys, i_reset_n, pk24, wvalid, wready, req, pvalid, pal, lwr;
  logic [2:0] bpp;
  logic [1:0] ord, kind;
  logic [31:0] wdata, lwd, lrd;
  logic [23:0] pdata;
  logic [7:0] laddr;
  logic [15:0] lut_m [256];
  logic [31:0] wq [12];
  int failures = 0;
  int num_checks = 0;
  lpup_top u_lpup_top (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_bits_per_pixel_sel(bpp), .i_word_ordering_sel(ord), .i_panel_kind_sel(kind),
    .i_packed_24(pk24), .i_word_valid(wvalid), .o_word_ready(wready), .i_word_data(wdata),
    .i_data_request(req), .o_pixel_valid(pvalid), .o_panel_data_bus(pdata),
    .o_palettized(pal), .i_lut_write(lwr), .i_lut_addr(laddr), .i_lut_wdata(lwd),
    .o_lut_rdata(lrd));
  lpup_word_src u_lpup_word_src (.i_clk_sys(i_clk_sys), .i_ready(wready),
    .o_valid(wvalid), .o_data(wdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Host writes a whole word, then reads the entry back
  task automatic lut_rw(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk_sys);
    lwr <= 1'b1;
    laddr <= a;
    lwd <= {16'hA5C3, v};
    @(posedge i_clk_sys);
    lwr <= 1'b0;
    lut_m[a] = v;
    repeat (2) @(posedge i_clk_sys);
    #1 check("lut entry", lrd, {16'h0000, v});
  endtask
  function automatic logic [23:0] expect_px(input int k, input int nb);
    logic [23:0] r;
    logic [15:0] e;
    int ppw, j, sh;
    ppw = 32 / nb;
    j = k % ppw;
    sh = j * nb;
    if (ord == lpup_pkg::ORD_BIG) sh = 32 - (j + 1) * nb;
    if (ord == lpup_pkg::ORD_BYTE_REV && nb < 8) sh = (sh / 8) * 8 + 8 - (j % (8 / nb) + 1) * nb;
    r = 24'(wq[k / ppw] >> sh) & 24'((1 << nb) - 1);
    if (pk24) r = 24'({wq[2], wq[1], wq[0]} >> (24 * k));
    e = lut_m[r[7:0]];
    if (nb > 8 || (kind == lpup_pkg::PANEL_STN_MONO && nb > 2)) return r;
    if (kind == lpup_pkg::PANEL_TFT) return {e[15:11], 3'h0, e[10:5], 2'h0, e[4:0], 3'h0};
    if (kind == lpup_pkg::PANEL_STN_MONO) return {20'h00000, e[15:12]};
    return {12'h000, e[15:12], e[10:7], e[4:1]};
  endfunction
  task automatic pull(input logic [23:0] exp);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk_sys);
      req <= 1'b1;
      @(posedge i_clk_sys);
      req <= 1'b0;
      #1;
      if (pvalid === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      results();
    end
    check("pixel", {8'h00, pdata}, {8'h00, exp});
  endtask
  task automatic run(input logic [1:0] kd, input logic [2:0] b, input logic [1:0] od,
    input logic pk, input int nw);
    int i, nb, np;
    @(posedge i_clk_sys);
    nb = (b == lpup_pkg::BPP_24) ? 24 : (1 << b);
    np = pk ? 4 : nw * (32 / nb);
    kind <= kd;
    bpp <= b;
    ord <= od;
    pk24 <= pk;
    for (i = 0; i < nw; i++) begin
      wq[i] = (32'h9E3779B9 * (i + nb + 1)) ^ {od, 30'h01234567};
      u_lpup_word_src.q.push_back(wq[i]);
    end
    repeat (30) @(posedge i_clk_sys);
    #1;
    check("buffer ready", {31'h0, wready}, {31'h0, nw < 9});
    check("palettized", {31'h0, pal}, {31'h0, nb <= 2 || (nb <= 8 && kd != 2'h1)});
    for (i = 0; i < np; i++) pull(expect_px(i, nb));
    $display("test kind %0d bpp %0d order %0d done", kd, b, od);
  endtask
  initial begin
    i_reset_n = 1'b0;
    {pk24, req, lwr, laddr, lwd, bpp, ord, kind} = '0;
    repeat (12) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 256; i++) lut_rw(8'(i), 16'(i * 40503 + 4660));
    $display("test table done");
    run(2'h0, 3'h0, 2'h0, 1'b0, 2);
    run(2'h0, 3'h1, 2'h1, 1'b0, 2);
    run(2'h0, 3'h2, 2'h2, 1'b0, 2);
    run(2'h0, 3'h3, 2'h1, 1'b0, 12);
    run(2'h0, 3'h4, 2'h1, 1'b0, 2);
    run(2'h0, 3'h5, 2'h0, 1'b0, 2);
    run(2'h0, 3'h5, 2'h0, 1'b1, 3);
    run(2'h1, 3'h0, 2'h2, 1'b0, 1);
    run(2'h1, 3'h1, 2'h0, 1'b0, 1);
    run(2'h1, 3'h2, 2'h0, 1'b0, 1);
    run(2'h2, 3'h3, 2'h0, 1'b0, 2);
    run(2'h2, 3'h4, 2'h0, 1'b0, 1);
    results();
  end
endmodule // lpup_top_tb
`default_nettype wire

// >>> verification/lpup_word_src.sv
// Memory word source standing before the block's input FIFO
`timescale 1ns/1ps
`default_nettype none
module lpup_word_src (
  input wire logic i_clk_sys,
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_data
);
  logic [31:0] q[$];
  initial begin
    o_valid = 1'b0;
    o_data = 32'h00000000;
  end
  // Word held until taken; idle data toggles so no stale word shows
  always @(posedge i_clk_sys) begin
    if (!o_valid || i_ready) begin
      if (q.size() > 0) begin
        o_valid <= 1'b1;
        o_data <= q.pop_front();
      end else begin
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
    end
  end
endmodule // lpup_word_src
`default_nettype wire
